// >>> rtl/scs_pkg.sv
// package: constants and request/answer types for the scratchpad and stack
package scs_pkg;
    localparam int RAM_DEPTH = 64;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int SP_W = 3;
    localparam int RET_W = 10;
    localparam int REG_SEL_W = 3;
    localparam logic [ADDR_W-1:0] STACK_BASE = 6'h08;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [SP_W-1:0] SP_STEP = 3'h1;
    localparam logic [ADDR_W-1:0] PTR0_ADDR = 6'h00;
    localparam logic [ADDR_W-1:0] PTR1_ADDR = 6'h01;
    localparam logic [ADDR_W-1:0] ODD_BYTE = 6'h01;
    localparam logic [DATA_W-1:0] RAM_RESET = 8'h00;
    localparam logic [DATA_W-3:0] HI_PAD = 6'h00;
    localparam logic [ADDR_W-REG_SEL_W-1:0] DIR_PAD = 3'h0;
    localparam logic [ADDR_W-SP_W-2:0] SLOT_PAD = 2'h0;
    localparam logic SLOT_LSB = 1'b0;
    localparam logic [SP_W-1:0] SP_LAST = 3'h7;
    localparam logic [ADDR_W-1:0] STACK_TOP = 6'h17;

    // kind of access requested by the execution unit
    typedef enum logic [2:0] {
        SCS_OP_IDLE,
        SCS_OP_DIRECT,
        SCS_OP_INDIRECT,
        SCS_OP_CALL,
        SCS_OP_RETURN
    } scs_op_t;

    // one request from the execution unit
    typedef struct packed {
        scs_op_t op;
        logic [REG_SEL_W-1:0] reg_sel;
        logic ptr_sel;
        logic wr;
        logic [DATA_W-1:0] wdata;
        logic [RET_W-1:0] ret_addr;
    } scs_req_t;

    // registered answer back to the execution unit
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] rdata;
        logic [ADDR_W-1:0] addr;
        logic [RET_W-1:0] ret_addr;
    } scs_rsp_t;
endpackage

// >>> rtl/scs_scratchpad_stack.sv
// scratchpad data memory with working registers and return-address stack
//
// Summary of operation
// - 64 by 8 data memory; every byte reachable indirectly.
// - bytes 0-7 selected directly by the instruction register field.
// - bytes 0 and 1 also serve as indirect pointers.
// - indirect access picks a pointer; its value addresses the operand.
// - pointers may address bytes 0-7 as well as higher ones.
// - bytes 8-23 hold subroutine return addresses.
// - three-bit pointer names the slot for the next return address.
// - call stores address at slot, then steps pointer up.
// - return steps pointer down, then reads the slot.
// - stack holds eight nested levels.
// - reset points the stack at byte 8.
// - each return address is ten bits over two bytes.
// - one pointer step moves the byte address by two.
// - unused stack bytes act as plain scratchpad.
// - program counter lives outside; only saved returns go to RAM.
// - program store is fixed 1K mask ROM, no external fetch.
//
// the execution unit presents one request per enabled clock edge on req_i;
// the answer is registered and shows on rsp_o one edge later
// direct and indirect reads return the byte as it stood before any write
// of the same request, so a read-modify-write needs no extra cycle
// indirect addresses use the low six bits of the pointer byte only;
// the two upper bits are ignored, so an out-of-range value aliases
// a call stores the pushed address at the current slot, low byte first,
// and steps the pointer up; a return steps down and reads that slot
// the pointer wraps silently; a ninth push overwrites the oldest entry
// bytes 8-23 are shared with the scratchpad; nothing guards them, so
// software that nests shallowly may use the upper slots as data
// clk_en_i low freezes the pointer, the answer and every byte
// reset is synchronous and clears all bytes, the pointer and the answer
`timescale 1ns/1ps
module scs_scratchpad_stack
    import scs_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire scs_req_t req_i,
    output scs_rsp_t rsp_o,
    output logic [SP_W-1:0] return_slot_pointer_o
);

    // storage; program counter and program ROM live in the core
    logic [DATA_W-1:0] mem_r [RAM_DEPTH];
    logic [SP_W-1:0] return_slot_pointer_r;
    logic [SP_W-1:0] return_slot_pointer_nxt;
    scs_rsp_t rsp_r;
    scs_rsp_t rsp_nxt;

    wire logic is_direct = req_i.op == SCS_OP_DIRECT;
    wire logic is_ind = req_i.op == SCS_OP_INDIRECT;
    wire logic is_call = req_i.op == SCS_OP_CALL;
    wire logic is_ret = req_i.op == SCS_OP_RETURN;

    // pointer register selection: byte 0 or byte 1
    wire logic [ADDR_W-1:0] ptr_loc = req_i.ptr_sel ? PTR1_ADDR : PTR0_ADDR;
    wire logic [DATA_W-1:0] indirect_ram_pointer = mem_r[ptr_loc];
    // upper pointer bits ignored; software keeps value <= 63
    wire logic [ADDR_W-1:0] ind_addr =
        indirect_ram_pointer[ADDR_W-1:0];
    // direct field reaches bytes 0-7 only
    // zero pad keeps the direct field inside the working bytes
    wire logic [ADDR_W-1:0] dir_addr = {DIR_PAD, req_i.reg_sel};

    // pop pointer: decrement first, wrapping modulo eight
    wire logic [SP_W-1:0] pop_ptr = return_slot_pointer_r - SP_STEP;
    wire logic [SP_W-1:0] slot_ptr = is_ret ? pop_ptr : return_slot_pointer_r;
    // two bytes per step, based at byte 8
    wire logic [ADDR_W-1:0] slot_even =
        STACK_BASE + {SLOT_PAD, slot_ptr, SLOT_LSB};
    wire logic [ADDR_W-1:0] slot_odd = slot_even | ODD_BYTE;

    // data address for scratchpad accesses
    wire logic [ADDR_W-1:0] data_addr = is_ind ? ind_addr : dir_addr;
    wire logic data_wr = (is_direct || is_ind) && req_i.wr;

    // saved address split: low byte even, high two bits odd
    wire logic [DATA_W-1:0] push_lo = req_i.ret_addr[DATA_W-1:0];
    wire logic [DATA_W-1:0] push_hi = {HI_PAD, req_i.ret_addr[RET_W-1:DATA_W]};
    wire logic [RET_W-1:0] pop_addr =
        {mem_r[slot_odd][RET_W-DATA_W-1:0], mem_r[slot_even]};

    // next stack pointer: push steps up after store, eight levels
    always_comb begin
        return_slot_pointer_nxt = return_slot_pointer_r;
        if (is_call) begin
            return_slot_pointer_nxt = return_slot_pointer_r + SP_STEP;
        end else if (is_ret) begin
            return_slot_pointer_nxt = pop_ptr;
        end
    end

    // answer: read data shows the addressed byte before any write
    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.valid = is_direct || is_ind || is_call || is_ret;
        if (is_direct || is_ind) begin
            rsp_nxt.addr = data_addr;
            rsp_nxt.rdata = mem_r[data_addr];
        end else if (is_call || is_ret) begin
            rsp_nxt.addr = slot_even;
        end
        if (is_ret) begin
            rsp_nxt.ret_addr = pop_addr;
        end
    end

    // stack pointer and answer registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            return_slot_pointer_r <= SP_RESET;
            rsp_r <= '0;
        end else if (clk_en_i) begin
            return_slot_pointer_r <= return_slot_pointer_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // memory writes; stack bytes are ordinary storage otherwise
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < RAM_DEPTH; i++) begin
                mem_r[i] <= RAM_RESET;
            end
        end else if (clk_en_i) begin
            if (data_wr) begin
                mem_r[data_addr] <= req_i.wdata;
            end else if (is_call) begin
                mem_r[slot_even] <= push_lo;
                mem_r[slot_odd] <= push_hi;
            end
        end
    end

    assign rsp_o = rsp_r;
    assign return_slot_pointer_o = return_slot_pointer_r;

    // checks
    AST_RESET_PTR: assert property (@(posedge clk_i)
        sys_rst_i |=> return_slot_pointer_o == SP_RESET)
        else $error("stack pointer not at first slot after reset");

    AST_PUSH_STEP: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && is_call |=>
            return_slot_pointer_o == $past(return_slot_pointer_o) + SP_STEP)
        else $error("call did not step pointer up by one");

    AST_POP_STEP: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && is_ret |=>
            return_slot_pointer_o == $past(return_slot_pointer_o) - SP_STEP)
        else $error("return did not step pointer down by one");

    AST_HOLD_PTR: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        !clk_en_i || !(is_call || is_ret) |=> $stable(return_slot_pointer_o))
        else $error("stack pointer moved without call or return");

    sequence push_s;
        clk_en_i && is_call && return_slot_pointer_r == SP_LAST;
    endsequence
    AST_WRAP: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        push_s |=> return_slot_pointer_o == SP_RESET)
        else $error("stack pointer did not wrap at eight levels");

    sequence call_then_ret_s;
        clk_en_i && is_call ##1 clk_en_i && is_ret;
    endsequence
    AST_ROUNDTRIP: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        call_then_ret_s |=> rsp_o.ret_addr == $past(req_i.ret_addr, 2))
        else $error("return address not recovered after call");

    AST_SLOT_EVEN: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && is_call |=> !rsp_o.addr[0] && rsp_o.addr >= STACK_BASE
            && rsp_o.addr ==
            STACK_BASE + {SLOT_PAD, $past(slot_ptr), SLOT_LSB})
        else $error("stack slot not on even byte");

    AST_DIRECT_LOW: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && is_direct |=> rsp_o.addr < STACK_BASE && rsp_o.valid)
        else $error("direct access left bytes 0-7");

    AST_IND_WRITE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && is_ind && req_i.wr && ind_addr != ptr_loc |=>
            mem_r[$past(ind_addr)] == $past(req_i.wdata))
        else $error("indirect write missed the pointed byte");

    // checks on stored bytes, answers and the pointer; the read checks compare the
    // registered result against the memory as it stood before the edge
    // named steps reused by the checks below
    sequence call_s;
        clk_en_i && is_call;
    endsequence
    sequence ret_s;
        clk_en_i && is_ret;
    endsequence
    sequence pop_at_base_s;
        clk_en_i && is_ret && return_slot_pointer_r == SP_RESET;
    endsequence
    sequence dir_s;
        clk_en_i && is_direct;
    endsequence
    sequence ind_s;
        clk_en_i && is_ind;
    endsequence
    sequence frozen_s;
        !clk_en_i;
    endsequence

    // pushed low byte lands in the even byte of the slot
    AST_CALL_LO_BYTE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        call_s |=> mem_r[$past(slot_even)] == $past(push_lo))
        else $error("pushed low byte not in even slot byte");

    // pushed upper bits land in the odd byte of the slot
    AST_CALL_HI_BYTE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        call_s |=> mem_r[$past(slot_odd)] == $past(push_hi))
        else $error("pushed upper bits not in odd slot byte");

    // unused bits of the odd byte stay clear
    AST_CALL_HI_PAD: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        call_s |=> mem_r[$past(slot_odd)][DATA_W-1:RET_W-DATA_W] == HI_PAD)
        else $error("odd slot byte carries stray upper bits");

    // stack slots stay inside bytes 8-23
    AST_STACK_AREA: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && (is_call || is_ret) |=>
            rsp_o.addr >= STACK_BASE && rsp_o.addr < STACK_TOP)
        else $error("stack slot outside the stack area");

    // a return reads the slot that the lowered pointer names
    AST_RET_SLOT: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ret_s |=> rsp_o.addr ==
            STACK_BASE + {SLOT_PAD, return_slot_pointer_o, SLOT_LSB})
        else $error("return read a slot other than the lowered one");

    // a return hands back both bytes of its slot
    AST_RET_DATA: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ret_s |=> rsp_o.ret_addr == {
            $past(mem_r[slot_odd][RET_W-DATA_W-1:0]),
            $past(mem_r[slot_even])})
        else $error("return address does not match slot bytes");

    // a return leaves its slot bytes untouched
    AST_RET_NO_WRITE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ret_s |=> mem_r[$past(slot_even)] == $past(mem_r[slot_even])
            && mem_r[$past(slot_odd)] == $past(mem_r[slot_odd]))
        else $error("return changed its slot bytes");

    // popping from the first slot wraps to the last
    AST_POP_WRAP: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        pop_at_base_s |=> return_slot_pointer_o == SP_LAST)
        else $error("stack pointer did not wrap on underflow");

    // direct read shows the old byte and its address
    AST_DIR_READ: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        dir_s |=> rsp_o.rdata == $past(mem_r[dir_addr])
            && rsp_o.addr == $past(dir_addr))
        else $error("direct read returned the wrong byte");

    // direct write lands in the selected working byte
    AST_DIR_WRITE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && is_direct && req_i.wr |=>
            mem_r[$past(dir_addr)] == $past(req_i.wdata))
        else $error("direct write missed the working byte");

    // indirect read shows the pointed byte and its address
    AST_IND_READ: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ind_s |=> rsp_o.rdata == $past(mem_r[ind_addr])
            && rsp_o.addr == $past(ind_addr))
        else $error("indirect read returned the wrong byte");

    // indirect address follows the chosen pointer byte
    AST_IND_PTR_SEL: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        ind_s |=> rsp_o.addr == $past(mem_r[ptr_loc][ADDR_W-1:0]))
        else $error("indirect address not taken from the pointer");

    // stack bytes take indirect writes like any other byte
    AST_IND_STACK_BYTE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && is_ind && req_i.wr && ind_addr >= STACK_BASE |=>
            mem_r[$past(ind_addr)] == $past(req_i.wdata))
        else $error("indirect write to a stack byte was lost");

    // enable low holds the answer and the pointer
    AST_FREEZE_STATE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        frozen_s |=> $stable(rsp_o) && $stable(return_slot_pointer_o))
        else $error("state moved while the enable was low");

    // enable low holds the addressed data byte and the even byte of the slot
    AST_FREEZE_MEM: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        frozen_s |=> mem_r[$past(data_addr)] == $past(mem_r[data_addr])
            && mem_r[$past(slot_even)] == $past(mem_r[slot_even]))
        else $error("memory changed while the enable was low");

    // reset clears the answer and the first stack byte
    AST_RESET_CLEAR: assert property (@(posedge clk_i)
        sys_rst_i |=> rsp_o == '0 && mem_r[STACK_BASE] == RAM_RESET)
        else $error("answer or stack byte not cleared by reset");

    // every accepted request gets an answer one edge later
    AST_ANSWER: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && (is_direct || is_ind || is_call || is_ret) |=>
            rsp_o.valid)
        else $error("request produced no answer");

    // an idle edge clears the answer flag
    AST_IDLE_QUIET: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        clk_en_i && !(is_direct || is_ind || is_call || is_ret) |=>
            !rsp_o.valid)
        else $error("answer flag set without a request");

endmodule // scs_scratchpad_stack

// >>> verification/scs_exec_model.sv
// execution-unit model that issues requests and collects answers
`timescale 1ns/1ps
module scs_exec_model
    import scs_pkg::*;
(
    input wire logic clk_i,
    input wire scs_rsp_t rsp_i,
    output scs_req_t req_o
);
    initial req_o = '0;

    // request for one enabled edge, then idle; answer read once settled
    task automatic xfer(input scs_req_t q, output scs_rsp_t s);
        @(posedge clk_i);
        req_o <= q;
        @(posedge clk_i);
        req_o <= '0;
        #1 s = rsp_i;
    endtask

    // two requests on consecutive edges, answer of the second
    task automatic xfer2(input scs_req_t q1, input scs_req_t q2,
                         output scs_rsp_t s);
        @(posedge clk_i);
        req_o <= q1;
        @(posedge clk_i);
        req_o <= q2;
        @(posedge clk_i);
        req_o <= '0;
        #1 s = rsp_i;
    endtask
endmodule // scs_exec_model

// >>> verification/scs_scratchpad_stack_tb.sv
// self-checking bench for the scratchpad and return-address stack
`timescale 1ns/1ps
module scs_scratchpad_stack_tb import scs_pkg::*;;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en = 1'b1;
    scs_req_t req;
    scs_rsp_t rsp;
    scs_rsp_t r;
    logic [SP_W-1:0] sp;
    logic [9:0] v;
    int n_errors = 0;
    int check_count = 0;

    always #4 clk_i = ~clk_i;

    scs_exec_model i_cpu (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));
    scs_scratchpad_stack i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en), .req_i(req), .rsp_o(rsp),
        .return_slot_pointer_o(sp));

    task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic go(scs_op_t op, logic [2:0] s, logic p, logic w,
                      logic [7:0] d, logic [9:0] a);
        i_cpu.xfer(scs_req_t'{op, s, p, w, d, a}, r);
    endtask

    task automatic results();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // state straight after reset release
    task automatic t_reset();
        @(posedge clk_i);
        #1;
        chk("pointer", 10'h000, 10'(sp));
        chk("valid", 10'h000, 10'(rsp.valid));
    endtask

    // fill the eight working bytes, then read them back
    task automatic t_direct();
        for (int i = 0; i < 8; i++) go(SCS_OP_DIRECT, i[2:0], 0, 1,
            8'h30 + 8'(i), 0);
        for (int i = 0; i < 8; i++) begin
            go(SCS_OP_DIRECT, i[2:0], 0, 0, 8'h00, 0);
            chk("direct data", 10'(8'h30 + 8'(i)), 10'(r.rdata));
            chk("direct addr", 10'(i), 10'(r.addr));
        end
    endtask

    // requests while the enable is low must leave every state alone
    task automatic t_freeze();
        @(posedge clk_i);
        clk_en <= 1'b0;
        go(SCS_OP_CALL, 0, 0, 0, 8'h00, 10'h155);
        chk("frozen valid", 10'h000, 10'(r.valid));
        chk("frozen pointer", 10'h000, 10'(sp));
        go(SCS_OP_DIRECT, 3'h2, 0, 1, 8'hee, 0);
        @(posedge clk_i);
        clk_en <= 1'b1;
        go(SCS_OP_DIRECT, 3'h2, 0, 0, 8'h00, 0);
        chk("frozen byte", 10'h032, 10'(r.rdata));
    endtask

    // top byte, an unused stack byte and a working byte via both pointers
    task automatic t_indirect();
        logic [5:0] tgt [3] = '{6'h3f, 6'h14, 6'h06};
        for (int k = 0; k < 3; k++) begin
            go(SCS_OP_DIRECT, 3'(k % 2), 0, 1, 8'(tgt[k]), 0);
            go(SCS_OP_INDIRECT, 0, k[0], 1, 8'ha5 ^ 8'(k), 0);
            go(SCS_OP_INDIRECT, 0, k[0], 0, 8'h00, 0);
            chk("ind data", 10'(8'ha5 ^ 8'(k)), 10'(r.rdata));
            chk("ind addr", 10'(tgt[k]), 10'(r.addr));
        end
    endtask

    // nine nested calls wrap onto slot 0, then eight returns unwind
    task automatic t_stack();
        scs_req_t qc;
        scs_req_t qr;
        for (int i = 0; i < 9; i++) begin
            go(SCS_OP_CALL, 0, 0, 0, 8'h00, 10'h2a5 + 10'(i * 77));
            chk("call slot", 10'(STACK_BASE) + 10'((i % 8) * 2),
                10'(r.addr));
            chk("pointer up", 10'((i + 1) % 8), 10'(sp));
        end
        v = 10'h2a5 + 10'(8 * 77);
        for (int b = 0; b < 2; b++) begin
            go(SCS_OP_DIRECT, 0, 0, 1, 8'h08 + 8'(b), 0);
            go(SCS_OP_INDIRECT, 0, 0, 0, 8'h00, 0);
            chk("saved byte", b ? 10'(v[9:8]) : 10'(v[7:0]),
                10'(r.rdata));
        end
        for (int k = 0; k < 8; k++) begin
            go(SCS_OP_RETURN, 0, 0, 0, 8'h00, 0);
            chk("return addr", 10'h2a5 + 10'((8 - k) * 77),
                r.ret_addr);
            chk("pointer down", 10'((8 - k) % 8), 10'(sp));
            chk("ret slot", 10'(STACK_BASE) + 10'(((8 - k) % 8) * 2),
                10'(r.addr));
        end
        qc = '{SCS_OP_CALL, 3'h0, 1'b0, 1'b0, 8'h00, 10'h1c3};
        qr = '{SCS_OP_RETURN, 3'h0, 1'b0, 1'b0, 8'h00, 10'h000};
        i_cpu.xfer2(qc, qr, r);
        chk("round trip", 10'h1c3, r.ret_addr);
        chk("pointer back", 10'h001, 10'(sp));
        chk("round slot", 10'(STACK_BASE) + 10'h002, 10'(r.addr));
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_direct();
        t_freeze();
        t_indirect();
        t_stack();
        results();
    end

    // watchdog against a hang
    initial begin
        #50000;
        n_errors++;
        results();
    end
endmodule // scs_scratchpad_stack_tb
